// >>> src/framer_defs.svh
// Constants for the API frame builder: field codes, offsets and sizes.
// Assumes inclusion by the frame builder module only.
`ifndef FRAMER_DEFS_SVH
`define FRAMER_DEFS_SVH
`define START_DELIM 8'h7E
`define TYPE_ADDR_UPD 8'h8E
`define TYPE_RX_PKT 8'h90
`define CSUM_BASE 8'hFF
`define RESV_ZERO 8'h00
`define RESV_RX 16'hFFFE
`define OPT_ACK_BIT 0
`define OPT_BCAST_BIT 1
`define OPT_METH_LSB 6
`define LEN_ADDR_UPD 16'h0012
`define LEN_RX_HDR 16'h000C
`define OFS_LEN_L 6'h02
`define OFS_TYPE 6'h03
`define OFS_UPD_RESV 6'h04
`define OFS_UPD_NEW 6'h05
`define OFS_UPD_OLD 6'h0D
`define OFS_UPD_END 6'h14
`define OFS_RX_SRC 6'h04
`define OFS_RX_RESV 6'h0C
`define OFS_RX_OPT 6'h0E
`define OFS_RX_DATA 6'h0F
`define ADDR_BYTES 4'h8
`endif

// >>> src/framer_pkg.sv
// Types shared by the frame builder and its testbench.
// Assumes framer_defs.svh sits beside it.
package framer_pkg;
  typedef struct packed {
    logic [63:0] src_addr;
    logic acked;
    logic bcast;
    logic [1:0] method;
  } rx_info_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } byte_beat_t;
endpackage : framer_pkg

// >>> src/payload_mem.sv
// Small payload store for one received packet.
// Assumes one write port and one registered read port on ref_clk.
`timescale 1ns/1ns
module payload_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) $error("payload_mem depth exceeds address range");
  end
  always_ff @(posedge ref_clk) begin
    if (wr_en) mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end
endmodule : payload_mem

// >>> src/api_receive_and_address_update_framer.sv
// Builds address-update and receive-packet API frames, one byte per beat.
// Assumes a host-side serial transmitter consumes tx_data when tx_ready is high.
//
// Summary of operation
// - Each frame starts with one start delimiter byte at offset zero.
// - Bytes one and two hold length of bytes between length and checksum.
// - Last byte is 0xFF minus low byte sum from offset three onward.
// - Aggregator address matching destination while idle overwrites it and emits type 0x8E frame; a hit while busy counts as dropped.
// - Address-update byte at offset four is always zero.
// - New destination at offset five, previous destination at offset thirteen.
// - With standard output selected, a packet started while idle with no aggregator hit emits type 0x90 frame.
// - Sender 64-bit address at offset four, most significant byte first.
// - Reserved 16-bit field at offset twelve sent as 0xFFFE.
// - Options byte at fourteen: bit0 acknowledged, bit1 broadcast, bits 2-5 zero.
// - Options bits 7:6 carry the delivery method code.
// - Payload bytes follow from offset fifteen; count from length field.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "framer_defs.svh"
module api_receive_and_address_update_framer
  import framer_pkg::*;
#(
  parameter int MAX_PAYLOAD = 64,
  parameter int PW = 6
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic agg_valid,
  input wire logic [63:0] agg_match_addr,
  input wire logic [63:0] agg_new_addr,
  input wire logic rx_start,
  input wire rx_info_t rx_info,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  output logic rx_busy,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready
);
  initial begin
    if (MAX_PAYLOAD < 1 || MAX_PAYLOAD > (1 << PW)) $error("MAX_PAYLOAD out of range");
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [2:0] REG_DEST_HIGH = 3'h0;
  localparam logic [2:0] REG_DEST_LOW = 3'h1;
  localparam logic [2:0] REG_OUT_FMT = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  logic [31:0] dest_addr_high;
  logic [31:0] dest_addr_low;
  logic output_format_option;
  logic [15:0] frame_count;
  logic [15:0] drop_count;
  wire [63:0] dest_addr = {dest_addr_high, dest_addr_low};
  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_COLLECT = 3'b001, S_DELIM = 3'b010, S_LEN_H = 3'b011,
    S_LEN_L = 3'b100, S_BODY = 3'b101, S_CSUM = 3'b110
  } state_t;
  state_t state;
  logic is_rx;
  logic [63:0] new_addr;
  logic [63:0] old_addr;
  rx_info_t info;
  logic [PW:0] pay_count;
  logic [PW:0] pay_idx;
  logic [5:0] ofs;
  logic [7:0] sum;
  logic [15:0] frame_len;
  logic [7:0] mem_rd;
  // One idle cycle per body byte gives the registered store time to answer
  logic mem_pending;
  wire agg_hit = agg_valid && (agg_match_addr == dest_addr);
  // An aggregator hit beats a packet start in the same cycle; the packet counts as dropped
  wire rx_take = rx_start && !output_format_option && state == S_IDLE && !agg_hit;
  wire beat = tx_valid && tx_ready;
  wire wr_store = state == S_COLLECT && rx_byte_valid && pay_count < (PW+1)'(MAX_PAYLOAD);
  wire [PW-1:0] rd_index = pay_idx[PW-1:0] + PW'(beat && state == S_BODY && ofs >= `OFS_RX_DATA);
  wire [7:0] opt_byte = {info.method, 4'h0, info.bcast, info.acked};
  wire [15:0] upd_len = `LEN_ADDR_UPD;
  wire [15:0] rx_len = `LEN_RX_HDR + 16'(pay_count);
  wire [63:0] body_addr = (is_rx || ofs < `OFS_UPD_OLD) ?
    (is_rx ? info.src_addr : new_addr) : old_addr;
  wire [5:0] addr_base = is_rx ? `OFS_RX_SRC : (ofs < `OFS_UPD_OLD ? `OFS_UPD_NEW : `OFS_UPD_OLD);
  wire [2:0] byte_sel = 3'(ofs - addr_base);
  wire [7:0] addr_byte = body_addr[8'(7 - byte_sel) * 8 +: 8];
  logic [7:0] body_byte;
  always_comb begin
    if (ofs == `OFS_TYPE) body_byte = is_rx ? `TYPE_RX_PKT : `TYPE_ADDR_UPD;
    else if (!is_rx && ofs == `OFS_UPD_RESV) body_byte = `RESV_ZERO;
    else if (!is_rx) body_byte = addr_byte;
    else if (ofs < `OFS_RX_RESV) body_byte = addr_byte;
    else if (ofs == `OFS_RX_RESV) body_byte = 8'(`RESV_RX >> 8);
    else if (ofs == 6'(`OFS_RX_RESV + 6'h01)) body_byte = 8'(`RESV_RX & 16'h00FF);
    else if (ofs == `OFS_RX_OPT) body_byte = opt_byte;
    else body_byte = mem_rd;
  end
  wire body_done = is_rx ? (ofs >= `OFS_RX_DATA && pay_idx + 1'b1 >= pay_count) :
    (ofs == `OFS_UPD_END);
  wire rx_hdr_done = is_rx && ofs == `OFS_RX_OPT && pay_count == '0;
  payload_mem #(.DEPTH(MAX_PAYLOAD), .AW(PW)) u_mem (
    .ref_clk(ref_clk),
    .wr_en(wr_store),
    .wr_addr(pay_count[PW-1:0]),
    .wr_data(rx_byte),
    .rd_addr(rd_index),
    .rd_data(mem_rd)
  );
  // Busy is registered so the pin never glitches while the sequencer settles
  wire next_busy = (state == S_IDLE) ? (agg_hit || rx_take) : !(state == S_CSUM && beat);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_busy <= 1'b0;
    end else begin
      rx_busy <= next_busy;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= S_IDLE;
      is_rx <= 1'b0;
      new_addr <= '0;
      old_addr <= '0;
      info <= '0;
      pay_count <= '0;
      pay_idx <= '0;
      ofs <= '0;
      sum <= 8'h00;
      frame_len <= 16'h0000;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      mem_pending <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (agg_hit) begin
            is_rx <= 1'b0;
            new_addr <= agg_new_addr;
            old_addr <= dest_addr;
            frame_len <= upd_len;
            state <= S_DELIM;
          end else if (rx_take) begin
            is_rx <= 1'b1;
            info <= rx_info;
            pay_count <= '0;
            state <= S_COLLECT;
          end
        end
        S_COLLECT: begin
          // Bytes past the store are dropped; the length counts only kept bytes
          if (wr_store) pay_count <= pay_count + 1'b1;
          if (rx_end) begin
            frame_len <= rx_len;
            state <= S_DELIM;
          end
        end
        S_DELIM: begin
          tx_valid <= 1'b1;
          tx_data <= `START_DELIM;
          tx_last <= 1'b0;
          pay_idx <= '0;
          state <= S_LEN_H;
        end
        S_LEN_H: if (beat) begin
          tx_data <= frame_len[15:8];
          state <= S_LEN_L;
        end
        S_LEN_L: if (beat) begin
          // Low length byte goes out from the body loop, which leaves it out of the sum
          tx_data <= frame_len[7:0];
          ofs <= `OFS_LEN_L;
          sum <= 8'h00;
          state <= S_BODY;
        end
        S_BODY: begin
          if (mem_pending) begin
            mem_pending <= 1'b0;
            tx_valid <= 1'b1;
            tx_data <= body_byte;
          end else if (beat) begin
            if (ofs >= `OFS_TYPE) sum <= sum + tx_data;
            if (ofs >= `OFS_RX_DATA) pay_idx <= pay_idx + 1'b1;
            if (body_done || rx_hdr_done) begin
              tx_data <= `CSUM_BASE - 8'(sum + tx_data);
              tx_last <= 1'b1;
              state <= S_CSUM;
            end else begin
              ofs <= ofs + 6'h01;
              tx_valid <= 1'b0;
              mem_pending <= 1'b1;
            end
          end
        end
        S_CSUM: if (beat) begin
          tx_valid <= 1'b0;
          tx_last <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  wire upd_commit = state == S_IDLE && agg_hit;
  wire drop_evt = (rx_start && !rx_take) || (agg_hit && state != S_IDLE);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dest_addr_high <= 32'h00000000;
      dest_addr_low <= 32'h00000000;
      output_format_option <= 1'b0;
      frame_count <= 16'h0000;
      drop_count <= 16'h0000;
      reg_rdata <= 32'h00000000;
    end else begin
      if (upd_commit) begin
        {dest_addr_high, dest_addr_low} <= agg_new_addr;
      end else if (reg_wr && reg_addr == REG_DEST_HIGH) dest_addr_high <= reg_wdata;
      else if (reg_wr && reg_addr == REG_DEST_LOW) dest_addr_low <= reg_wdata;
      if (reg_wr && reg_addr == REG_OUT_FMT) output_format_option <= reg_wdata[0];
      if (state == S_CSUM && beat) frame_count <= frame_count + 16'h0001;
      if (drop_evt) drop_count <= drop_count + 16'h0001;
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_DEST_HIGH: reg_rdata <= dest_addr_high;
          REG_DEST_LOW: reg_rdata <= dest_addr_low;
          REG_OUT_FMT: reg_rdata <= {31'h0, output_format_option};
          REG_STATUS: reg_rdata <= {drop_count, frame_count};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_DELIM: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_DELIM |=> tx_valid && tx_data == `START_DELIM)
    else $error("frame did not open with start delimiter");
  AST_LEN: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_LEN_H && beat |=> tx_data == frame_len[15:8])
    else $error("length high byte wrong");
  AST_CSUM: assert property (@(posedge ref_clk) disable iff (rst)
    tx_last && tx_valid |-> 8'(tx_data + sum) == `CSUM_BASE)
    else $error("checksum does not close the sum");
  AST_UPD: assert property (@(posedge ref_clk) disable iff (rst)
    upd_commit |=> dest_addr == $past(agg_new_addr) && !is_rx && state == S_DELIM)
    else $error("aggregator hit not taken");
  AST_RESV0: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_BODY && !is_rx && ofs == `OFS_UPD_RESV && tx_valid |-> tx_data == `RESV_ZERO)
    else $error("reserved byte not zero");
  AST_TYPE: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_BODY && ofs == `OFS_TYPE && tx_valid |->
      tx_data == (is_rx ? `TYPE_RX_PKT : `TYPE_ADDR_UPD))
    else $error("frame type byte wrong");
  AST_RXRESV: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_BODY && is_rx && ofs == `OFS_RX_RESV && tx_valid |-> tx_data == 8'(`RESV_RX >> 8))
    else $error("reserved field high byte wrong");
  AST_RXTAKE: assert property (@(posedge ref_clk) disable iff (rst)
    rx_start && output_format_option && state == S_IDLE |=> !is_rx || state != S_COLLECT)
    else $error("receive frame with non-standard output");
  AST_OPT: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_BODY && is_rx && ofs == `OFS_RX_OPT && tx_valid |-> tx_data[5:2] == 4'h0)
    else $error("reserved option bits set");
  AST_OPTLO: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_BODY && is_rx && ofs == `OFS_RX_OPT && tx_valid |->
      tx_data[1:0] == {info.bcast, info.acked})
    else $error("acknowledge or broadcast option bit wrong");
  AST_METH: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_BODY && is_rx && ofs == `OFS_RX_OPT && tx_valid |-> tx_data[7:6] == info.method)
    else $error("delivery method bits wrong");
  AST_NEWADDR: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_BODY && !is_rx && ofs == `OFS_UPD_NEW && tx_valid |-> tx_data == new_addr[63:56])
    else $error("new address does not open with its top byte");
  AST_OLDADDR: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_BODY && !is_rx && ofs == `OFS_UPD_END && tx_valid |-> tx_data == old_addr[7:0])
    else $error("previous address does not close with its bottom byte");
  AST_SRC: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_BODY && is_rx && ofs == `OFS_RX_SRC && tx_valid |->
      tx_data == info.src_addr[63:56])
    else $error("sender address does not open with its top byte");
  AST_RXRESVLO: assert property (@(posedge ref_clk) disable iff (rst)
    state == S_BODY && is_rx && ofs == 6'(`OFS_RX_RESV + 6'h01) && tx_valid |->
      tx_data == 8'(`RESV_RX & 16'h00FF))
    else $error("reserved field low byte wrong");
  AST_PAYLEN: assert property (@(posedge ref_clk) disable iff (rst)
    tx_last && tx_valid && is_rx |-> pay_idx == pay_count)
    else $error("payload bytes sent differ from bytes stored");
  COV_UPD: cover property (@(posedge ref_clk) upd_commit);
  COV_RX: cover property (@(posedge ref_clk) rx_take);
  COV_END: cover property (@(posedge ref_clk) tx_last && beat && is_rx);
  COV_DROP: cover property (@(posedge ref_clk) drop_evt);
endmodule : api_receive_and_address_update_framer

// >>> tb/host_sink.sv
// Host side of the API byte stream: accepts beats and keeps them.
// Assumes the framer holds each beat until tx_ready is seen high.
`timescale 1ns/1ns
module host_sink (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] got[$];
  int frames;
  // --------------------------------------------------------------
  // Acceptance
  // --------------------------------------------------------------
  // A stalling host only takes every other cycle, the slow case
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_ready <= 1'b0;
      frames <= 0;
    end else begin
      tx_ready <= stall ? !tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        if (tx_last) begin
          frames <= frames + 1;
        end
      end
    end
  end
endmodule : host_sink

// >>> tb/test_api_receive_and_address_update_framer.sv
// Self-checking bench for the API frame builder.
// Assumes host_sink as the serial consumer and ref_clk at 250 MHz.
`timescale 1ns/1ns
module test_api_receive_and_address_update_framer;
  import framer_pkg::*;
  logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, agg_valid = 0, stall = 0;
  logic rx_start = 0, rx_byte_valid = 0, rx_end = 0, rx_busy, tx_valid, tx_last, tx_ready;
  logic [2:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [63:0] agg_match_addr = 0, agg_new_addr = 0;
  logic [7:0] rx_byte = 0, tx_data;
  rx_info_t rx_info = '0;
  logic [7:0] exp_q[$];
  int errors = 0, n_compared = 0;
  always #2 ref_clk = !ref_clk;
  api_receive_and_address_update_framer u_api_receive_and_address_update_framer (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .agg_valid(agg_valid),
    .agg_match_addr(agg_match_addr),
    .agg_new_addr(agg_new_addr),
    .rx_start(rx_start),
    .rx_info(rx_info),
    .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte),
    .rx_end(rx_end),
    .rx_busy(rx_busy),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last),
    .tx_ready(tx_ready)
  );
  host_sink u_host_sink (
    .ref_clk(ref_clk),
    .rst(rst),
    .stall(stall),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last),
    .tx_ready(tx_ready)
  );
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic results;
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic add64(input logic [63:0] v);
    for (int i = 7; i >= 0; i--) exp_q.push_back(v[i*8 +: 8]);
  endtask : add64
  // Wraps the body held in exp_q into a whole frame
  task automatic seal(input logic [7:0] t);
    logic [7:0] s;
    logic [15:0] n;
    s = t;
    n = 16'(exp_q.size() + 1);
    foreach (exp_q[i]) s += exp_q[i];
    exp_q.push_front(t);
    exp_q.push_front(n[7:0]);
    exp_q.push_front(n[15:8]);
    exp_q.push_front(8'h7E);
    exp_q.push_back(8'hFF - s);
  endtask : seal
  task automatic take_frame;
    int f0;
    f0 = u_host_sink.frames;
    for (int i = 0; i <= 800 && u_host_sink.frames == f0; i++) begin
      if (i == 800) begin
        errors++;
        results;
      end
      @(posedge ref_clk);
    end
    chk(u_host_sink.got.size(), exp_q.size());
    foreach (exp_q[i]) chk(u_host_sink.got[i], exp_q[i]);
    u_host_sink.got.delete();
    exp_q.delete();
  endtask : take_frame
  task automatic send_rx(input logic [1:0] m, input int n);
    @(posedge ref_clk);
    rx_start <= 1;
    rx_info <= {64'h1020304050607080 + 64'(m), m[0], m[1], m};
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      rx_start <= 0; rx_byte_valid <= 1; rx_byte <= 8'hA0 + 8'(i);
    end
    @(posedge ref_clk);
    rx_byte_valid <= 0; rx_end <= 1;
    @(posedge ref_clk);
    rx_end <= 0;
  endtask : send_rx
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic addr_update;
    wr(0, 32'h0A0B0C0D);
    wr(1, 32'h11112222);
    @(posedge ref_clk);
    agg_valid <= 1; agg_match_addr <= 64'h0A0B0C0D_11110000;
    agg_new_addr <= 64'h55;
    @(posedge ref_clk);
    agg_valid <= 0;
    repeat (40) @(posedge ref_clk);
    chk(u_host_sink.frames, 0);
    rd(1, 32'h11112222);
    @(posedge ref_clk);
    stall <= 1;
    agg_valid <= 1; agg_match_addr <= 64'h0A0B0C0D_11112222;
    agg_new_addr <= 64'hF0E0D0C0_B0A09080;
    @(posedge ref_clk);
    agg_valid <= 0;
    exp_q.push_back(8'h00);
    add64(64'hF0E0D0C0_B0A09080);
    add64(64'h0A0B0C0D_11112222);
    seal(8'h8E);
    take_frame;
    rd(0, 32'hF0E0D0C0);
    rd(1, 32'hB0A09080);
  endtask : addr_update
  task automatic rx_all_methods;
    for (int m = 0; m < 4; m++) begin
      stall <= m[0];
      send_rx(2'(m), m + 1);
      #1 chk(rx_busy, 1'b1);
      add64(64'h1020304050607080 + 64'(m));
      exp_q.push_back(8'hFF);
      exp_q.push_back(8'hFE);
      exp_q.push_back({2'(m), 4'h0, m[1], m[0]});
      for (int i = 0; i <= m; i++) exp_q.push_back(8'hA0 + 8'(i));
      seal(8'h90);
      take_frame;
    end
  endtask : rx_all_methods
  task automatic rx_suppressed;
    rd(2, 32'h0);
    wr(2, 32'h1);
    rd(2, 32'h1);
    send_rx(2'h3, 2);
    #1 chk(rx_busy, 1'b0);
    repeat (100) @(posedge ref_clk);
    chk(u_host_sink.frames, 5);
    rd(5, 32'h0);
    rd(3, 32'h00010005);
  endtask : rx_suppressed
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 0;
    addr_update;
    rx_all_methods;
    rx_suppressed;
    results;
  end
endmodule : test_api_receive_and_address_update_framer
